/* inc/mbr_cfg.svh */
// constants for the bit-read responder: codes, limits, crc and timing
`ifndef MBR_CFG_SVH
`define MBR_CFG_SVH
`define FC_READ_COILS   8'h01
`define FC_READ_INPUTS  8'h02
`define FC_EXC_FLAG     8'h80
`define EXC_ILLEGAL_FC  8'h01
`define EXC_BAD_ADDR    8'h02
`define EXC_BAD_VALUE   8'h03
`define MAX_BITS        16'h07D0
`define QUERY_LEN       4'h8
`define MIN_FRAME       4'h4
`define CRC_INIT        16'hFFFF
`define CRC_POLY        16'hA001
`define CRC_RESIDUE     16'h0000
// timing: one character at 9600 baud, 11 bit times
`define CLK_PERIOD_NS   50
`define CHAR_TIME_NS    1146000
`define GAP_TIME_NS     ((`CHAR_TIME_NS * 7) / 2)
`define GAP_CYCLES      ((`GAP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CNT_W       24
`endif

/* inc/mbr_pkg.sv */
// types shared by the bit-read responder modules
package mbr_pkg;
  typedef enum logic [3:0] {
    idle_s      = 4'h0,
    check_s     = 4'h1,
    send_addr_s = 4'h3,
    send_fc_s   = 4'h2,
    send_cnt_s  = 4'h6,
    build_s     = 4'h7,
    send_data_s = 4'h5,
    crc_lo_s    = 4'h4,
    crc_hi_s    = 4'hC
  } state_t;
  typedef logic [7:0] byte_t;
endpackage : mbr_pkg

/* inc/crc_if.sv */
// crc accumulator port bundle between the responder and its crc unit
interface crc_if;
  logic        init;
  logic        en;
  logic [7:0]  data;
  logic [15:0] crc;
  modport unit (input init, input en, input data, output crc);
  modport user (output init, output en, output data, input crc);
endinterface : crc_if

/* design/crc16_unit.sv */
// byte-wide crc-16 accumulator, reflected polynomial
`include "mbr_cfg.svh"
module crc16_unit (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic ce,
  // accumulator port
  crc_if.unit       cif
);
  import mbr_pkg::*;

  logic [15:0] crc_r;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ `CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction : crc_step

  // RULE19 - reflected crc update
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      crc_r <= `CRC_INIT;
    end else if (ce) begin
      if (cif.en) begin
        crc_r <= crc_step(cif.init ? `CRC_INIT : crc_r, cif.data);
      end else if (cif.init) begin
        crc_r <= `CRC_INIT;
      end
    end
  end

  assign cif.crc = crc_r;
endmodule : crc16_unit

/* design/silence_timer.sv */
// line-silence detector marking the end of a received frame
`include "mbr_cfg.svh"
module silence_timer #(
  parameter int GAP_CYCLES = `GAP_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic ce,
  // line activity and frame end
  input  wire logic activity,
  output logic      gap_pulse
);
  import mbr_pkg::*;

  logic [`GAP_CNT_W-1:0] cnt_r;
  logic                  armed_r;

  // RULE20 - silence ends frame
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_r     <= '0;
      armed_r   <= 1'b0;
      gap_pulse <= 1'b0;
    end else if (ce) begin
      gap_pulse <= 1'b0;
      if (activity) begin
        cnt_r   <= '0;
        armed_r <= 1'b1;
      end else if (armed_r) begin
        if (cnt_r == GAP_CYCLES[`GAP_CNT_W-1:0] - 1'b1) begin
          armed_r   <= 1'b0;
          gap_pulse <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule : silence_timer

/* design/modbus_bit_read_responder.sv */
// slave responder for the coil-read and input-read bit functions
// Summary of operation
// RULE1 - every response carries a two-byte crc over address, code and data
// RULE2 - master recomputes response crc and ignores mismatching messages
// RULE3 - queries whose crc does not check are silently discarded
// RULE4 - code 01h returns a contiguous coil range, up to 2000 bits
// RULE5 - coil addresses are zero based
// RULE6 - first coil in bit 0 of first byte, later coils upward
// RULE7 - query: address, code, start, count, crc; eight bytes
// RULE8 - response: address, code, byte count n, n data bytes, crc
// RULE9 - byte count is bits over eight rounded up, padding zero
// RULE10 - only bits of installed hardware are readable
// RULE11 - bad bit gives exception 02h, bad count or format 03h
// RULE12 - each error increments its own communication counter; an illegal function code (01h) increments none
// RULE13 - code 02h returns a contiguous input range, up to 2000 bits
// RULE14 - inputs zero based, packed from bit 0 upward
// RULE15 - input response laid out like the coil response
// RULE16 - lowest input of each row at rightmost bit
// RULE17 - exceptions set the code's top bit and carry the exception code
// RULE18 - answer only our own slave address, otherwise stay silent
// RULE19 - crc-16 initial ffff, polynomial a001, low byte first
// RULE20 - a silence of 3.5 characters ends a frame
`include "mbr_cfg.svh"
module modbus_bit_read_responder #(
  parameter int GAP_CYCLES = `GAP_CYCLES
) (
  // clock, reset, enable
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          ce,
  // received bytes from the serial receiver
  input  wire mbr_pkg::byte_t rx_byte,
  input  wire logic          rx_valid,
  // bytes to the serial transmitter
  output mbr_pkg::byte_t     tx_byte,
  output logic               tx_valid,
  input  wire logic          tx_ready,
  // configuration and installed hardware
  input  wire mbr_pkg::byte_t slave_id,
  input  wire logic [15:0]   coil_limit,
  input  wire logic [15:0]   input_limit,
  // bit lookup into the relay, data back one cycle after the address
  output logic [15:0]        bit_addr,
  output logic               bit_space,
  input  wire logic          bit_data,
  // communication counters
  output logic [15:0]        cnt_invalid_addr,
  output logic [15:0]        cnt_illegal_reg,
  output logic [15:0]        cnt_bad_format
);
  import mbr_pkg::*;

  crc_if cif ();

  state_t      st_r;
  byte_t       buf_r [0:7];
  logic [3:0]  len_r;
  logic        gap;
  byte_t       fc_r;
  byte_t       exc_r;
  logic        is_exc_r;
  logic [15:0] start_r;
  logic [15:0] count_r;
  logic [15:0] pos_r;
  logic [2:0]  k_r;
  logic        phase_r;
  byte_t       shift_r;
  byte_t       nbytes_r;
  byte_t       left_r;
  byte_t       byte_nxt;
  logic        sending;
  logic        load_fire;
  logic        take;
  logic [15:0] q_start;
  logic [15:0] q_count;
  logic [16:0] q_end;
  logic [15:0] q_limit;
  logic        q_bad_fc;
  logic        accept;

  crc16_unit u_crc (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .cif      (cif)
  );

  silence_timer #(.GAP_CYCLES(GAP_CYCLES)) u_gap (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .ce        (ce),
    .activity  (rx_valid),
    .gap_pulse (gap)
  );

  function automatic logic is_crc_state(input state_t s);
    return (s == crc_lo_s) || (s == crc_hi_s);
  endfunction : is_crc_state

  function automatic logic is_send_state(input state_t s);
    return (s == send_addr_s) || (s == send_fc_s) || (s == send_cnt_s) ||
           (s == send_data_s) || is_crc_state(s);
  endfunction : is_send_state

  assign sending   = is_send_state(st_r);
  assign load_fire = sending && !tx_valid;
  assign take      = tx_valid && tx_ready;

  // query fields as received
  assign q_start  = {buf_r[2], buf_r[3]};
  assign q_count  = {buf_r[4], buf_r[5]};
  assign q_end    = {1'b0, q_start} + {1'b0, q_count};
  assign q_limit  = (buf_r[1] == `FC_READ_INPUTS) ? input_limit : coil_limit;
  assign q_bad_fc = (buf_r[1] != `FC_READ_COILS) && (buf_r[1] != `FC_READ_INPUTS);
  assign accept   = gap && (len_r >= `MIN_FRAME) && (cif.crc == `CRC_RESIDUE) &&
                    (buf_r[0] == slave_id);

  // RULE8 - response byte order
  always_comb begin
    case (st_r)
      send_addr_s: byte_nxt = buf_r[0];
      // RULE17 - exception flag in code
      send_fc_s:   byte_nxt = is_exc_r ? (fc_r | `FC_EXC_FLAG) : fc_r;
      send_cnt_s:  byte_nxt = is_exc_r ? exc_r : nbytes_r;
      send_data_s: byte_nxt = shift_r;
      // RULE19 - low crc byte first
      crc_lo_s:    byte_nxt = cif.crc[7:0];
      crc_hi_s:    byte_nxt = cif.crc[15:8];
      default:     byte_nxt = 8'h00;
    endcase
  end

  // rx bytes feed the check; on reply the header and data feed a fresh crc
  // RULE1 - crc over response
  always_comb begin
    // restart after the reply, else the next query is checked from a stale value
    cif.init = ((st_r == idle_s) && gap) || (st_r == check_s) ||
               ((st_r == crc_hi_s) && take);
    cif.en   = ((st_r == idle_s) && rx_valid) || (load_fire && !is_crc_state(st_r));
    cif.data = (st_r == idle_s) ? rx_byte : byte_nxt;
  end

  // frame capture; bytes beyond eight only count toward the length
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      len_r <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else if (ce) begin
      if (st_r == idle_s) begin
        if (rx_valid) begin
          if (len_r < `QUERY_LEN) begin
            buf_r[len_r[2:0]] <= rx_byte;
          end
          if (len_r != 4'hF) begin
            len_r <= gap ? 4'h1 : len_r + 1'b1;
          end
        end else if (gap && !accept) begin
          // an accepted frame keeps its length for validation
          len_r <= 4'h0;
        end
      end else if (st_r == crc_hi_s && take) begin
        len_r <= 4'h0;
      end
    end
  end

  // state sequencing
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r <= idle_s;
    end else if (ce) begin
      case (st_r)
        idle_s: begin
          // RULE3 - residue must be zero
          // RULE18 - own address only
          if (accept) begin
            st_r <= check_s;
          end
        end
        check_s: begin
          st_r <= send_addr_s;
        end
        send_addr_s: begin
          if (take) st_r <= send_fc_s;
        end
        send_fc_s: begin
          if (take) st_r <= send_cnt_s;
        end
        send_cnt_s: begin
          if (take) st_r <= is_exc_r ? crc_lo_s : build_s;
        end
        build_s: begin
          if (phase_r && k_r == 3'h7) st_r <= send_data_s;
        end
        send_data_s: begin
          if (take) st_r <= (left_r == 8'h01) ? crc_lo_s : build_s;
        end
        crc_lo_s: begin
          if (take) st_r <= crc_hi_s;
        end
        crc_hi_s: begin
          if (take) st_r <= idle_s;
        end
        default: begin
          st_r <= idle_s;
        end
      endcase
    end
  end

  // query validation, in priority order
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fc_r     <= 8'h00;
      exc_r    <= 8'h00;
      is_exc_r <= 1'b0;
      start_r  <= 16'h0000;
      count_r  <= 16'h0000;
      nbytes_r <= 8'h00;
    end else if (ce && st_r == check_s) begin
      fc_r    <= buf_r[1];
      start_r <= q_start;
      count_r <= q_count;
      // RULE9 - round up to bytes
      nbytes_r <= 8'((q_count + 16'h0007) >> 3);
      is_exc_r <= 1'b1;
      if (q_bad_fc) begin
        exc_r <= `EXC_ILLEGAL_FC;
      // RULE7 - eight-byte query format
      // RULE11 - format gives 03h
      end else if (len_r != `QUERY_LEN) begin
        exc_r <= `EXC_BAD_VALUE;
      // RULE4 - at most 2000 bits
      // RULE13 - same limit inputs
      end else if (q_count == 16'h0000 || q_count > `MAX_BITS) begin
        exc_r <= `EXC_BAD_VALUE;
      // RULE10 - installed bits only
      // RULE11 - bad bit gives 02h
      end else if (q_end > {1'b0, q_limit}) begin
        exc_r <= `EXC_BAD_ADDR;
      end else begin
        is_exc_r <= 1'b0;
        exc_r    <= 8'h00;
      end
    end
  end

  // RULE12 - error counters
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_invalid_addr <= 16'h0000;
      cnt_illegal_reg  <= 16'h0000;
      cnt_bad_format   <= 16'h0000;
    end else if (ce && st_r == check_s && !q_bad_fc) begin
      if (len_r != `QUERY_LEN) begin
        cnt_bad_format <= cnt_bad_format + 1'b1;
      end else if (q_count == 16'h0000 || q_count > `MAX_BITS) begin
        cnt_illegal_reg <= cnt_illegal_reg + 1'b1;
      end else if (q_end > {1'b0, q_limit}) begin
        cnt_invalid_addr <= cnt_invalid_addr + 1'b1;
      end
    end
  end

  // bit gathering: address in one cycle, relay data sampled the next
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pos_r     <= 16'h0000;
      k_r       <= 3'h0;
      phase_r   <= 1'b0;
      shift_r   <= 8'h00;
      bit_addr  <= 16'h0000;
      bit_space <= 1'b0;
    end else if (ce) begin
      if (st_r == check_s) begin
        pos_r     <= 16'h0000;
        k_r       <= 3'h0;
        phase_r   <= 1'b0;
        bit_space <= (buf_r[1] == `FC_READ_INPUTS);
      end else if (st_r == build_s) begin
        if (!phase_r) begin
          // RULE5 - zero-based addressing
          // RULE14 - zero-based inputs
          bit_addr <= start_r + pos_r;
          phase_r  <= 1'b1;
        end else begin
          // RULE6 - lsb holds first bit
          // RULE16 - lowest at right
          // RULE9 - pad with zero
          shift_r <= {(pos_r < count_r) ? bit_data : 1'b0, shift_r[7:1]};
          pos_r   <= pos_r + 1'b1;
          k_r     <= k_r + 1'b1;
          phase_r <= 1'b0;
        end
      end
    end
  end

  // transmit handshake; valid drops at least one cycle between bytes
  // RULE15 - shared response path
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
      left_r   <= 8'h00;
    end else if (ce) begin
      if (st_r == check_s) begin
        left_r <= 8'((q_count + 16'h0007) >> 3);
      end
      if (take) begin
        tx_valid <= 1'b0;
        if (st_r == send_data_s) begin
          left_r <= left_r - 1'b1;
        end
      end else if (load_fire) begin
        tx_valid <= 1'b1;
        tx_byte  <= byte_nxt;
      end
    end
  end
endmodule : modbus_bit_read_responder

/* verif/mbr_assertions.sv */
// port checker for the bit-read responder
module mbr_assertions
  import mbr_pkg::*;
#(
  parameter int GAP_CYCLES = 20
) (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           nrst,
  // link
  input  wire logic           rx_valid,
  input  wire mbr_pkg::byte_t tx_byte,
  input  wire logic           tx_valid,
  input  wire logic           tx_ready,
  input  wire mbr_pkg::byte_t slave_id,
  // counters
  input  wire logic [15:0]    cnt_invalid_addr,
  input  wire logic [15:0]    cnt_illegal_reg,
  input  wire logic [15:0]    cnt_bad_format
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] quiet_r;
  logic [15:0] idx_r;
  logic        exc_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // idle cycles since the last query byte, saturating
  always_ff @(posedge core_clk) begin
    if (!nrst || rx_valid) quiet_r <= '0;
    else if (quiet_r != '1) quiet_r <= quiet_r + 32'h0000_0001;
  end
  // position of the byte inside the reply
  always_ff @(posedge core_clk) begin
    if (!nrst || rx_valid) idx_r <= '0;
    else if (tx_valid && tx_ready) idx_r <= idx_r + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) exc_r <= 1'b0;
    else if (tx_valid && tx_ready && idx_r == 16'h0001) exc_r <= tx_byte[7];
  end
  chk_hold_until_take: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("tx byte not held");
  chk_drop_after_take: assert property (
    tx_valid && tx_ready |=> !tx_valid) else $error("tx valid held after take");
  // past reset guard: one-edge resets would look like a jump
  chk_addr_cnt_step: assert property (
    $changed(cnt_invalid_addr) && $past(nrst) |-> cnt_invalid_addr == $past(cnt_invalid_addr)
    + 16'h0001 && $stable(cnt_illegal_reg) && $stable(cnt_bad_format)) else $error("addr cnt");
  chk_reg_cnt_step: assert property (
    $changed(cnt_illegal_reg) && $past(nrst) |-> cnt_illegal_reg == $past(cnt_illegal_reg)
    + 16'h0001 && $stable(cnt_invalid_addr) && $stable(cnt_bad_format)) else $error("reg cnt");
  chk_fmt_cnt_step: assert property (
    $changed(cnt_bad_format) && $past(nrst) |-> cnt_bad_format == $past(cnt_bad_format)
    + 16'h0001 && $stable(cnt_invalid_addr) && $stable(cnt_illegal_reg)) else $error("fmt cnt");
  chk_gap_first: assert property (
    $rose(tx_valid) |-> quiet_r >= GAP_CYCLES) else $error("reply before line silence");
  chk_addr_echo: assert property (
    tx_valid && idx_r == 16'h0000 |-> tx_byte == slave_id) else $error("wrong reply address");
  chk_exc_code: assert property (
    tx_valid && idx_r == 16'h0002 && exc_r |-> tx_byte inside {8'h01, 8'h02, 8'h03})
    else $error("bad exception code");
  chk_byte_count: assert property (
    tx_valid && idx_r == 16'h0002 && !exc_r |-> tx_byte inside {[8'h01 : 8'hFA]})
    else $error("byte count out of range");
endmodule : mbr_assertions

bind modbus_bit_read_responder mbr_assertions #(.GAP_CYCLES(GAP_CYCLES)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .rx_valid(rx_valid), .tx_byte(tx_byte),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .slave_id(slave_id),
  .cnt_invalid_addr(cnt_invalid_addr), .cnt_illegal_reg(cnt_illegal_reg),
  .cnt_bad_format(cnt_bad_format));

/* verif/mbr_master_model.sv */
// serial-link master model: sends queries, collects replies
module mbr_master_model (
  // clock
  input  wire logic           core_clk,
  // query bytes
  output mbr_pkg::byte_t      rx_byte,
  output logic                rx_valid,
  // reply bytes
  input  wire mbr_pkg::byte_t tx_byte,
  input  wire logic           tx_valid,
  output logic                tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import mbr_pkg::*;
  byte_t rsp[$];
  int    stall  = 0;
  int    wait_n = 0;
  initial begin
    rx_byte  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  function automatic logic [15:0] crc16(byte_t q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16
  // reply used only if crc residue is zero
  function automatic logic rsp_good();
    return rsp.size() > 2 && crc16(rsp) == 16'h0000;
  endfunction : rsp_good
  // whole frame; idle line shows the inverted last byte, not a stale copy
  task automatic send(byte_t q[$]);
    foreach (q[i]) begin
      @(negedge core_clk);
      rx_byte  = q[i];
      rx_valid = 1'b1;
      @(negedge core_clk);
      rx_valid = 1'b0;
      rx_byte  = ~q[i];
    end
  endtask : send
  always @(posedge core_clk) if (tx_valid && tx_ready) rsp.push_back(tx_byte);
  // stalls before each byte, so holding of tx is exercised
  always @(negedge core_clk) begin
    if (!tx_valid || tx_ready) begin
      tx_ready = 1'b0;
      wait_n   = 0;
    end else if (wait_n < stall) wait_n++;
    else tx_ready = 1'b1;
  end
endmodule : mbr_master_model

/* verif/test_modbus_bit_read_responder.sv */
// self-checking bench for the bit-read responder
module test_modbus_bit_read_responder;
  timeunit 1ns;
  timeprecision 1ns;
  import mbr_pkg::*;
  localparam int GAP = 20;
  logic        core_clk    = 1'b0;
  logic        nrst        = 1'b0;
  logic        ce          = 1'b1;
  logic        bit_data    = 1'b0;
  byte_t       slave_id    = 8'h11;
  logic [15:0] coil_limit  = 16'h07D0;
  logic [15:0] input_limit = 16'h0040;
  byte_t       rx_byte, tx_byte;
  logic        rx_valid, tx_valid, tx_ready, bit_space;
  logic [15:0] bit_addr, cnt_invalid_addr, cnt_illegal_reg, cnt_bad_format;
  int          failures = 0;
  int          n_checks = 0;
  int          freeze   = 0;
  always #25 core_clk = ~core_clk;
  function automatic logic pat(logic [15:0] a, logic s);
    return a[0] ^ a[2] ^ s;
  endfunction : pat
  // relay stand-in, settled before the sampling edge
  always @(negedge core_clk) bit_data <= pat(bit_addr, bit_space);
  modbus_bit_read_responder #(.GAP_CYCLES(GAP)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .slave_id(slave_id),
    .coil_limit(coil_limit), .input_limit(input_limit), .bit_addr(bit_addr),
    .bit_space(bit_space), .bit_data(bit_data), .cnt_invalid_addr(cnt_invalid_addr),
    .cnt_illegal_reg(cnt_illegal_reg), .cnt_bad_format(cnt_bad_format));
  mbr_master_model u_mst (
    .core_clk(core_clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));
  task automatic check(string what, logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // mode 1 spoils the crc, mode 2 drops the last count byte
  task automatic query(byte_t id, byte_t fc, logic [15:0] st, logic [15:0] n, int mode);
    byte_t       q[$];
    logic [15:0] c;
    int          quiet;
    q = '{id, fc, st[15:8], st[7:0], n[15:8], n[7:0]};
    if (mode == 2) void'(q.pop_back());
    c = u_mst.crc16(q);
    if (mode == 1) c = ~c;
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    u_mst.rsp.delete();
    u_mst.send(q);
    // ce low must hold the silence timer, so no reply while frozen
    if (freeze != 0) begin
      ce = 1'b0;
      repeat (GAP + 10) @(negedge core_clk);
      check("frozen", 16'(tx_valid), 16'd0);
      ce = 1'b1;
    end
    repeat (GAP + 4) @(negedge core_clk);
    quiet = 0;
    for (int i = 0; i < 8000 && quiet < 60; i++) begin
      @(negedge core_clk);
      quiet = tx_valid ? 0 : quiet + 1;
    end
    check("reply end", 16'(quiet), 16'd60);
  endtask : query
  task automatic expect_rsp(string what, byte_t e[$]);
    logic [15:0] c;
    c = u_mst.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    check({what, " size"}, 16'(u_mst.rsp.size()), 16'(e.size()));
    check({what, " crc"}, 16'(u_mst.rsp_good()), 16'd1);
    foreach (e[i]) check(what, 16'(u_mst.rsp[i]), 16'(e[i]));
  endtask : expect_rsp
  task automatic read_ok(byte_t fc, logic [15:0] st, logic [15:0] n);
    byte_t e[$];
    byte_t b;
    e = '{slave_id, fc, 8'((n + 16'd7) >> 3)};
    for (int j = 0; j < (n + 7) / 8; j++) begin
      b = 8'h00;
      for (int k = 0; k < 8; k++) if (j * 8 + k < n) b[k] = pat(st + 16'(j * 8 + k), fc[1]);
      e.push_back(b);
    end
    query(slave_id, fc, st, n, 0);
    expect_rsp("read", e);
  endtask : read_ok
  task automatic read_exc(byte_t fc, logic [15:0] st, logic [15:0] n, int mode, byte_t code);
    byte_t e[$];
    e = '{slave_id, fc | 8'h80, code};
    query(slave_id, fc, st, n, mode);
    expect_rsp("exception", e);
  endtask : read_exc
  task automatic t_coil_read();
    read_ok(8'h01, 16'h0003, 16'h000A);
    u_mst.stall = 2;
    read_ok(8'h01, 16'h0000, 16'h07D0);
    read_ok(8'h01, 16'h07C6, 16'h000A);
    $display("coil read done");
  endtask : t_coil_read
  task automatic t_input_read();
    u_mst.stall = 1;
    freeze = 1;
    read_ok(8'h02, 16'h0000, 16'h0008);
    freeze = 0;
    read_ok(8'h02, 16'h003D, 16'h0003);
    $display("input read done");
  endtask : t_input_read
  task automatic t_discard();
    query(slave_id, 8'h01, 16'h0000, 16'h0008, 1);
    check("bad crc", 16'(u_mst.rsp.size()), 16'd0);
    query(8'h12, 8'h01, 16'h0000, 16'h0008, 0);
    check("other id", 16'(u_mst.rsp.size()), 16'd0);
    check("silent cnt", cnt_invalid_addr | cnt_illegal_reg | cnt_bad_format, 16'd0);
    $display("discard done");
  endtask : t_discard
  task automatic t_errors();
    read_exc(8'h01, 16'h07CB, 16'h000A, 0, 8'h02);
    read_exc(8'h02, 16'h003E, 16'h0004, 0, 8'h02);
    read_exc(8'h01, 16'h0000, 16'h0000, 0, 8'h03);
    read_exc(8'h02, 16'h0000, 16'h07D1, 0, 8'h03);
    read_exc(8'h01, 16'h0000, 16'h0008, 2, 8'h03);
    read_exc(8'h03, 16'h0000, 16'h0008, 0, 8'h01);
    check("cnt addr", cnt_invalid_addr, 16'd2);
    check("cnt reg", cnt_illegal_reg, 16'd2);
    check("cnt fmt", cnt_bad_format, 16'd1);
    $display("errors done");
  endtask : t_errors
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    t_coil_read();
    t_input_read();
    t_discard();
    t_errors();
    print_verdict();
  end
  // all tests need well under 20000 cycles
  initial begin
    #(50 * 60000);
    failures++;
    print_verdict();
  end
endmodule : test_modbus_bit_read_responder
